// ### rtl/stage_seq_pkg.sv
// Purpose: constants shared by the stage program runner and its helpers
// Assumes: 25 MHz system clock, classic Wishbone register access
// Notes: all stage values are held in tenths (percent or time unit)
//
// Behaviour
// - mode 0: one pass, then stop
// - zero-time stages are skipped
// - ramp time scales with frequency difference
// - mode 1: hold last stage until stop command
// - mode 2: loop until stop command
// - no retention: restart from stage 0
// - retention: resume stage with remaining time
// - signed stage frequency, negative runs reverse
// - full scale maps to maximum frequency
// - stage time 0 to 6553.5, tenth steps
// - time unit seconds or minutes
package stage_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TENTH_SEC_MS = 100;
  localparam int TENTH_SEC_CYCLES = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int MIN_PER_SEC = 60;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int STAGES = 16;
  localparam int STAGE_W = 4;
  localparam int FREQ_W = 16;
  localparam int TIME_W = 16;
  localparam logic signed [FREQ_W-1:0] FREQ_FULL_SCALE = 16'sd1000;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
  localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MAXF_ADDR = 8'h08;
  localparam logic [7:0] ACCEL_ADDR = 8'h0C;
  localparam logic [7:0] DECEL_ADDR = 8'h10;
  localparam logic [7:0] OUTF_ADDR = 8'h14;
  localparam logic [7:0] RAMP_ADDR = 8'h18;
  localparam logic [7:0] FREQ_BASE = 8'h40;
  localparam logic [7:0] TIME_BASE = 8'h80;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RETAIN_BIT = 2;
  localparam int CTRL_UNIT_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] MAXF_RESET = 16'h01F4;
  localparam logic [15:0] ACCEL_RESET = 16'h0064;
  localparam logic [15:0] DECEL_RESET = 16'h00C8;

  typedef enum logic [1:0] {MODE_ONE_PASS, MODE_HOLD_LAST, MODE_LOOP} seq_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_RUN, ST_HOLD} seq_state_t;

endpackage

// ### rtl/ramp_time_calc.sv
// Purpose: ramp time between two stage frequencies
// Assumes: frequencies in signed tenths of percent, result in ramp units
// Notes: one registered stage of latency
module ramp_time_calc
  import stage_seq_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // operands
  input wire logic signed [stage_seq_pkg::FREQ_W-1:0] freq_new,
  input wire logic signed [stage_seq_pkg::FREQ_W-1:0] freq_old,
  input wire logic [15:0] accel_time,
  input wire logic [15:0] decel_time,
  // result
  output logic [15:0] ramp_time
);
  import stage_seq_pkg::*;

  logic signed [FREQ_W:0] diff;
  logic [FREQ_W:0] mag;
  logic [15:0] rate;
  logic [33:0] prod;
  logic [33:0] quot;

  // |new - old| / full scale * accel or decel time
  always_comb
  begin
    diff = {freq_new[FREQ_W-1], freq_new} - {freq_old[FREQ_W-1], freq_old};
    mag = diff[FREQ_W] ? unsigned'(-diff) : unsigned'(diff);
    rate = (mag_up(freq_new, freq_old)) ? accel_time : decel_time;
    prod = {17'h0_0000, mag} * {18'h0_0000, rate};
    quot = prod / {18'h0_0000, 16'(FREQ_FULL_SCALE)};
  end

  // magnitude rising means acceleration
  function automatic logic mag_up(input logic signed [FREQ_W-1:0] a,
                                  input logic signed [FREQ_W-1:0] b);
    logic [FREQ_W-1:0] ma;
    logic [FREQ_W-1:0] mb;
    ma = a[FREQ_W-1] ? FREQ_W'(-a) : a;
    mb = b[FREQ_W-1] ? FREQ_W'(-b) : b;
    return ma >= mb;
  endfunction

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      ramp_time <= 16'h0000;
    else
      ramp_time <= quot[15:0];
  end

endmodule

// ### rtl/stage_program_runner.sv
// Purpose: sixteen-stage speed sequencer with Wishbone registers
// Assumes: run and stop commands are one-cycle pulses, power_fail level
// Notes: retained state survives power_fail while RSTN stays high
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
module stage_program_runner
  import stage_seq_pkg::*;
#(
  parameter int TICK_CYCLES = stage_seq_pkg::TENTH_SEC_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // run/stop command source
  input wire logic RUN_CMD,
  input wire logic STOP_CMD,
  input wire logic POWER_FAIL,
  // ramp generator
  output logic signed [stage_seq_pkg::FREQ_W-1:0] TARGET_FREQ,
  output logic REVERSE,
  output logic RUNNING,
  output logic [15:0] RAMP_TIME,
  output logic [stage_seq_pkg::STAGE_W-1:0] STAGE
);
  import stage_seq_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0] freq_reg [STAGES];
  logic [TIME_W-1:0] time_reg [STAGES];
  logic [31:0] ctrl_reg;
  logic [15:0] maxf_reg;
  logic [15:0] accel_reg;
  logic [15:0] decel_reg;
  seq_state_t state_reg;
  logic [STAGE_W-1:0] stage_reg;
  logic [TIME_W-1:0] remain_reg;
  logic [31:0] tick_cnt_reg;
  logic [5:0] unit_cnt_reg;
  logic signed [FREQ_W-1:0] prev_freq_reg;
  logic [STAGE_W:0] seek_cnt_reg;
  logic saved_valid_reg;
  logic power_fail_reg;
  logic [31:0] out_freq_reg;
  logic [15:0] ramp_w;
  logic tenth_tick;
  seq_mode_t mode;
  logic wb_req;

  assign mode = seq_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    return r;
  endfunction

  function automatic logic is_last(input logic [STAGE_W-1:0] s);
    return s == STAGE_W'(STAGES - 1);
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= wb_req;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ctrl_reg <= CTRL_RESET;
      maxf_reg <= MAXF_RESET;
      accel_reg <= ACCEL_RESET;
      decel_reg <= DECEL_RESET;
      for (int i = 0; i < STAGES; i++)
      begin
        freq_reg[i] <= FREQ_RESET;
        time_reg[i] <= TIME_RESET;
      end
    end
    else if (wb_req && WB_WE_I)
    begin
      if (WB_ADR_I == CTRL_ADDR)
        ctrl_reg <= merge(ctrl_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_000F;
      else if (WB_ADR_I == MAXF_ADDR)
        maxf_reg <= 16'(merge({16'h0000, maxf_reg}, WB_DAT_I, WB_SEL_I));
      else if (WB_ADR_I == ACCEL_ADDR)
        accel_reg <= 16'(merge({16'h0000, accel_reg}, WB_DAT_I, WB_SEL_I));
      else if (WB_ADR_I == DECEL_ADDR)
        decel_reg <= 16'(merge({16'h0000, decel_reg}, WB_DAT_I, WB_SEL_I));
      else if (WB_ADR_I[7:6] == FREQ_BASE[7:6] && WB_ADR_I[1:0] == 2'b00)
        freq_reg[WB_ADR_I[5:2]] <=
          16'(merge({16'h0000, freq_reg[WB_ADR_I[5:2]]}, WB_DAT_I, WB_SEL_I));
      else if (WB_ADR_I[7:6] == TIME_BASE[7:6] && WB_ADR_I[1:0] == 2'b00)
        time_reg[WB_ADR_I[5:2]] <=
          16'(merge({16'h0000, time_reg[WB_ADR_I[5:2]]}, WB_DAT_I, WB_SEL_I));
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      WB_DAT_O <= 32'h0000_0000;
    else if (wb_req && !WB_WE_I)
    begin
      WB_DAT_O <= 32'h0000_0000;
      if (WB_ADR_I == CTRL_ADDR)
        WB_DAT_O <= ctrl_reg;
      else if (WB_ADR_I == STATUS_ADDR)
        WB_DAT_O <= {9'h000, remain_reg, saved_valid_reg, state_reg == ST_RUN,
                     RUNNING, stage_reg};
      else if (WB_ADR_I == MAXF_ADDR)
        WB_DAT_O <= {16'h0000, maxf_reg};
      else if (WB_ADR_I == ACCEL_ADDR)
        WB_DAT_O <= {16'h0000, accel_reg};
      else if (WB_ADR_I == DECEL_ADDR)
        WB_DAT_O <= {16'h0000, decel_reg};
      else if (WB_ADR_I == OUTF_ADDR)
        WB_DAT_O <= out_freq_reg;
      else if (WB_ADR_I == RAMP_ADDR)
        WB_DAT_O <= {16'h0000, RAMP_TIME};
      else if (WB_ADR_I[7:6] == FREQ_BASE[7:6])
        WB_DAT_O <= {{16{freq_reg[WB_ADR_I[5:2]][FREQ_W-1]}}, freq_reg[WB_ADR_I[5:2]]};
      else if (WB_ADR_I[7:6] == TIME_BASE[7:6])
        WB_DAT_O <= {16'h0000, time_reg[WB_ADR_I[5:2]]};
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN || state_reg != ST_RUN || power_fail_reg)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      unit_cnt_reg <= 6'h00;
    end
    else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 32'h0000_0000;
      if (!ctrl_reg[CTRL_UNIT_BIT] || unit_cnt_reg == 6'(MIN_PER_SEC - 1))
        unit_cnt_reg <= 6'h00;
      else
        unit_cnt_reg <= unit_cnt_reg + 6'h01;
    end
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  // seconds or minutes per tenth
  assign tenth_tick = tick_cnt_reg == 32'(TICK_CYCLES - 1) &&
                      (!ctrl_reg[CTRL_UNIT_BIT] || unit_cnt_reg == 6'(MIN_PER_SEC - 1));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      power_fail_reg <= 1'b0;
    else
      power_fail_reg <= POWER_FAIL;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state_reg <= ST_IDLE;
      stage_reg <= '0;
      remain_reg <= TIME_RESET;
      seek_cnt_reg <= '0;
      saved_valid_reg <= 1'b0;
    end
    else if (power_fail_reg)
    begin
      if (state_reg == ST_RUN && ctrl_reg[CTRL_RETAIN_BIT])
        saved_valid_reg <= 1'b1;
      else if (state_reg != ST_IDLE)
        saved_valid_reg <= 1'b0;
      if (!ctrl_reg[CTRL_RETAIN_BIT])
      begin
        stage_reg <= '0;
        remain_reg <= TIME_RESET;
      end
      state_reg <= ST_IDLE;
    end
    else if (STOP_CMD)
    begin
      state_reg <= ST_IDLE;
      saved_valid_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (RUN_CMD && saved_valid_reg && ctrl_reg[CTRL_RETAIN_BIT])
          begin
            state_reg <= ST_RUN;
            saved_valid_reg <= 1'b0;
          end
          else if (RUN_CMD)
          begin
            stage_reg <= '0;
            seek_cnt_reg <= '0;
            saved_valid_reg <= 1'b0;
            state_reg <= ST_SEEK;
          end
        end
        ST_SEEK:
        begin
          if (time_reg[stage_reg] != TIME_RESET)
          begin
            remain_reg <= time_reg[stage_reg];
            state_reg <= ST_RUN;
          end
          else if (seek_cnt_reg == (STAGE_W+1)'(STAGES))
            state_reg <= ST_IDLE;
          else
          begin
            seek_cnt_reg <= seek_cnt_reg + 1'b1;
            if (is_last(stage_reg))
            begin
              if (mode == MODE_LOOP)
                stage_reg <= '0;
              else
                state_reg <= (mode == MODE_HOLD_LAST) ? ST_HOLD : ST_IDLE;
            end
            else
              stage_reg <= stage_reg + 1'b1;
          end
        end
        ST_RUN:
        begin
          if (tenth_tick)
          begin
            if (remain_reg > 16'h0001)
              remain_reg <= remain_reg - 16'h0001;
            else
            begin
              remain_reg <= TIME_RESET;
              seek_cnt_reg <= '0;
              if (!is_last(stage_reg))
              begin
                stage_reg <= stage_reg + 1'b1;
                state_reg <= ST_SEEK;
              end
              else if (mode == MODE_LOOP)
              begin
                stage_reg <= '0;
                state_reg <= ST_SEEK;
              end
              else if (mode == MODE_HOLD_LAST)
                state_reg <= ST_HOLD;
              else
                state_reg <= ST_IDLE;
            end
          end
        end
        ST_HOLD:
          state_reg <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs to the ramp generator
  // ----------------------------------------------------------------
  ramp_time_calc u_ramp (
    .CLK(CLK),
    .RSTN(RSTN),
    .freq_new(signed'(freq_reg[stage_reg])),
    .freq_old(prev_freq_reg),
    .accel_time(accel_reg),
    .decel_time(decel_reg),
    .ramp_time(ramp_w)
  );

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      TARGET_FREQ <= '0;
      REVERSE <= 1'b0;
      RUNNING <= 1'b0;
      RAMP_TIME <= 16'h0000;
      STAGE <= '0;
      prev_freq_reg <= '0;
      out_freq_reg <= 32'h0000_0000;
    end
    else
    begin
      RUNNING <= state_reg == ST_RUN || state_reg == ST_HOLD;
      STAGE <= stage_reg;
      RAMP_TIME <= ramp_w;
      // hold keeps the target of the last timed stage
      if (state_reg == ST_RUN)
      begin
        TARGET_FREQ <= signed'(freq_reg[stage_reg]);
        REVERSE <= freq_reg[stage_reg][FREQ_W-1];
        out_freq_reg <= 32'(signed'(freq_reg[stage_reg]) * signed'({1'b0, maxf_reg})
                        / FREQ_FULL_SCALE);
        prev_freq_reg <= TARGET_FREQ;
      end
      else if (state_reg == ST_IDLE)
      begin
        TARGET_FREQ <= '0;
        REVERSE <= 1'b0;
        out_freq_reg <= 32'h0000_0000;
        prev_freq_reg <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_one_pass_stop: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_reg == ST_RUN && tenth_tick && remain_reg <= 16'h0001 && is_last(stage_reg)
     && mode == MODE_ONE_PASS && !STOP_CMD && !power_fail_reg) |=> state_reg == ST_IDLE)
    else $error("mode 0 did not stop after last stage");
  chk_zero_skip: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_reg == ST_SEEK && time_reg[stage_reg] == TIME_RESET) |=> state_reg != ST_RUN)
    else $error("running a zero-time stage");
  chk_hold_last: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_reg == ST_HOLD && !STOP_CMD && !power_fail_reg)
    |=> state_reg == ST_HOLD && $stable(TARGET_FREQ))
    else $error("hold stage left without stop");
  chk_loop_restart: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_reg == ST_RUN && tenth_tick && remain_reg <= 16'h0001 && is_last(stage_reg)
     && mode == MODE_LOOP && !STOP_CMD && !power_fail_reg)
    |=> state_reg == ST_SEEK && stage_reg == '0)
    else $error("loop mode did not restart");
  chk_no_retain: assert property (@(posedge CLK) disable iff (!RSTN)
    (power_fail_reg && !ctrl_reg[CTRL_RETAIN_BIT]) |=> stage_reg == '0)
    else $error("stage kept without retention");
  chk_retain_keep: assert property (@(posedge CLK) disable iff (!RSTN)
    (power_fail_reg && ctrl_reg[CTRL_RETAIN_BIT]) |=> $stable(stage_reg) && $stable(remain_reg))
    else $error("retained stage lost");
  chk_reverse_sign: assert property (@(posedge CLK) disable iff (!RSTN)
    RUNNING |-> REVERSE == TARGET_FREQ[FREQ_W-1] || $changed(STAGE))
    else $error("direction mismatch");
  chk_timer_tick: assert property (@(posedge CLK) disable iff (!RSTN)
    (state_reg == ST_RUN && tenth_tick && remain_reg > 16'h0001 && !STOP_CMD && !power_fail_reg)
    |=> remain_reg == $past(remain_reg) - 16'h0001)
    else $error("stage timer missed a tick");

endmodule

// ### tb/ramp_gen_model.sv
// Purpose: run/stop command source and ramp generator model
// Assumes: commands change just after a rising edge
// Notes: slews one step a cycle toward the stage target
module ramp_gen_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // from sequencer
  input wire logic signed [stage_seq_pkg::FREQ_W-1:0] TARGET_FREQ,
  input wire logic RUNNING,
  // commands
  output logic RUN_CMD,
  output logic STOP_CMD,
  output logic POWER_FAIL
);
  timeunit 1ns;
  timeprecision 1ns;
  import stage_seq_pkg::*;
  logic signed [FREQ_W-1:0] out_freq;
  initial
  begin
    RUN_CMD = 1'b0;
    STOP_CMD = 1'b0;
    POWER_FAIL = 1'b0;
  end
  // below zero the motor turns in reverse
  always_ff @(posedge CLK)
  begin
    if (!RSTN || !RUNNING)
      out_freq <= 16'sh0000;
    else if (out_freq < TARGET_FREQ)
      out_freq <= out_freq + 16'sh0001;
    else if (out_freq > TARGET_FREQ)
      out_freq <= out_freq - 16'sh0001;
  end
  task send_cmd(input logic stop);
    @(posedge CLK);
    RUN_CMD <= !stop;
    STOP_CMD <= stop;
    @(posedge CLK);
    RUN_CMD <= 1'b0;
    STOP_CMD <= 1'b0;
  endtask
  task set_power(input logic fail);
    @(posedge CLK);
    POWER_FAIL <= fail;
  endtask
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for the stage program runner
// Assumes: short tick of TK cycles, single Wishbone accesses
// Notes: each scenario judges its own results
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import stage_seq_pkg::*;
  localparam int TK = 4;
  logic clk;
  logic rstn;
  logic cyc;
  logic stb;
  logic we;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dat;
  logic [31:0] dato;
  logic ack;
  logic run_cmd;
  logic stop_cmd;
  logic pfail;
  logic signed [FREQ_W-1:0] tfreq;
  logic rev;
  logic running;
  logic [15:0] ramp;
  logic [STAGE_W-1:0] stage;
  int mismatches = 0;
  int num_checks = 0;
  int cnt = 0;
  always #20 clk = ~clk;
  always @(posedge clk)
    cnt <= cnt + 1;
  stage_program_runner #(.TICK_CYCLES(TK)) i_stage_program_runner (
    .CLK(clk), .RSTN(rstn),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .RUN_CMD(run_cmd), .STOP_CMD(stop_cmd), .POWER_FAIL(pfail),
    .TARGET_FREQ(tfreq), .REVERSE(rev), .RUNNING(running),
    .RAMP_TIME(ramp), .STAGE(stage)
  );
  ramp_gen_model i_ramp_gen_model (
    .CLK(clk), .RSTN(rstn), .TARGET_FREQ(tfreq), .RUNNING(running),
    .RUN_CMD(run_cmd), .STOP_CMD(stop_cmd), .POWER_FAIL(pfail)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    acc(1'b1, a, d, s, q);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, e);
  endtask
  function logic [7:0] idx(input int i);
    return 8'(i * 4);
  endfunction
  function logic [31:0] in_range(input int c0, input int lo, input int hi);
    return {31'h0, (cnt - c0) >= lo && (cnt - c0) <= hi};
  endfunction
  task prog(input int n, input logic [15:0] f, input logic [15:0] t);
    wr(FREQ_BASE + idx(n), {{16{f[15]}}, f});
    wr(TIME_BASE + idx(n), {16'h0000, t});
  endtask
  task clear_prog();
    for (int i = 0; i < STAGES; i++)
      prog(i, 16'h0000, 16'h0000);
  endtask
  // until running matches, and the stage too while running
  task wait_state(input int s, input logic r, input int lim);
    int n;
    n = 0;
    while (!(running === r && (!r || stage === 4'(s))) && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task start(input logic [31:0] ctrl);
    wr(CTRL_ADDR, ctrl);
    i_ramp_gen_model.send_cmd(1'b0);
  endtask
  task cut_power();
    repeat (5 * TK) @(posedge clk);
    i_ramp_gen_model.set_power(1'b1);
    repeat (4) @(posedge clk);
    i_ramp_gen_model.set_power(1'b0);
    i_ramp_gen_model.send_cmd(1'b0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task s_regs();
    rdchk(CTRL_ADDR, 32'h0000_0000);
    rdchk(MAXF_ADDR, {16'h0000, MAXF_RESET});
    rdchk(ACCEL_ADDR, {16'h0000, ACCEL_RESET});
    rdchk(DECEL_ADDR, {16'h0000, DECEL_RESET});
    for (int i = 0; i < STAGES; i++)
    begin
      rdchk(FREQ_BASE + idx(i), 32'h0000_0000);
      rdchk(TIME_BASE + idx(i), 32'h0000_0000);
    end
    i_ramp_gen_model.send_cmd(1'b0);
    repeat (30) @(posedge clk);
    chk({31'h0, running}, 32'h0000_0000);
    prog(15, 16'hFC18, 16'hFFFF);
    wr(8'hFC, 32'hFFFF_FFFF);
    rdchk(TIME_BASE + idx(15), 32'h0000_FFFF);
    rdchk(FREQ_BASE + idx(15), 32'hFFFF_FC18);
    wr(TIME_BASE + idx(15), 32'h1234_5612, 4'h1);
    rdchk(TIME_BASE + idx(15), 32'h0000_FF12);
    rdchk(8'hFC, 32'h0000_0000);
  endtask
  task s_one_pass();
    int c0;
    clear_prog();
    wr(ACCEL_ADDR, 32'h0000_000A);
    wr(DECEL_ADDR, 32'h0000_0014);
    prog(0, 16'h01F4, 16'h0006);
    prog(2, 16'hFED4, 16'h0011);
    start(32'h0000_0000);
    wait_state(0, 1'b1, 40);
    chk({28'h0, stage}, 32'h0000_0000);
    chk({16'h0, tfreq}, 32'h0000_01F4);
    chk({31'h0, rev}, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({16'h0, ramp}, 32'h0000_0005);
    rdchk(OUTF_ADDR, 32'h0000_00FA);
    wait_state(2, 1'b1, 6 * TK + 20);
    c0 = cnt;
    chk({28'h0, stage}, 32'h0000_0002);
    chk({16'h0, tfreq}, 32'h0000_FED4);
    chk({31'h0, rev}, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({16'h0, ramp}, 32'h0000_0010);
    rdchk(OUTF_ADDR, 32'hFFFF_FF6A);
    wait_state(0, 1'b0, 17 * TK + 20);
    chk(in_range(c0, 16 * TK, 17 * TK + 4), 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk({31'h0, running}, 32'h0000_0000);
  endtask
  task s_hold();
    clear_prog();
    prog(0, 16'hFF38, 16'h0003);
    start(32'h0000_0001);
    wait_state(0, 1'b1, 40);
    repeat (3 * TK + 60) @(posedge clk);
    chk({31'h0, running}, 32'h0000_0001);
    chk({16'h0, tfreq}, 32'h0000_FF38);
    chk({31'h0, rev}, 32'h0000_0001);
    chk({31'h0, i_ramp_gen_model.out_freq[FREQ_W-1]}, 32'h0000_0001);
    rdchk(STATUS_ADDR, 32'h0000_001F);
    i_ramp_gen_model.send_cmd(1'b1);
    wait_state(0, 1'b0, 20);
    chk({31'h0, running}, 32'h0000_0000);
  endtask
  task s_loop();
    clear_prog();
    prog(0, 16'h0064, 16'h0002);
    prog(15, 16'hFF9C, 16'h0002);
    start(32'h0000_0002);
    wait_state(15, 1'b1, 4 * TK + 40);
    wait_state(0, 1'b1, 2 * TK + 20);
    chk({27'h0, running, stage}, 32'h0000_0010);
    wait_state(15, 1'b1, 2 * TK + 30);
    chk({27'h0, running, stage}, 32'h0000_001F);
    i_ramp_gen_model.send_cmd(1'b1);
    wait_state(0, 1'b0, 20);
    chk({31'h0, running}, 32'h0000_0000);
  endtask
  task s_minutes();
    int c0;
    clear_prog();
    prog(15, 16'h0064, 16'h0002);
    start(32'h0000_0008);
    wait_state(15, 1'b1, 40);
    c0 = cnt;
    wait_state(0, 1'b0, 120 * TK + 40);
    chk(in_range(c0, 60 * TK, 120 * TK + 4), 32'h0000_0001);
  endtask
  task s_retain();
    int c0;
    clear_prog();
    prog(0, 16'h0064, 16'h0002);
    prog(1, 16'h012C, 16'h0014);
    start(32'h0000_0000);
    wait_state(1, 1'b1, 4 * TK + 40);
    cut_power();
    wait_state(0, 1'b1, 40);
    chk({28'h0, stage}, 32'h0000_0000);
    i_ramp_gen_model.send_cmd(1'b1);
    wait_state(0, 1'b0, 20);
    start(32'h0000_0004);
    wait_state(1, 1'b1, 4 * TK + 40);
    cut_power();
    wait_state(1, 1'b1, 40);
    c0 = cnt;
    chk({28'h0, stage}, 32'h0000_0001);
    chk({16'h0, tfreq}, 32'h0000_012C);
    wait_state(0, 1'b0, 20 * TK + 20);
    chk(in_range(c0, 12 * TK, 15 * TK + 4), 32'h0000_0001);
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_one_pass();
    s_hold();
    s_loop();
    s_minutes();
    s_retain();
    final_report();
  end
endmodule
